// ---- include/pcc_params.svh ----
// Register offsets, field positions, reset values and timing counts of the loop clock control.
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define PCC_OFS_LOOP_CONTROL 8'h00
`define PCC_OFS_BANDWIDTH_CONTROL 8'h04
`define PCC_OFS_MULTIPLIER_HIGH 8'h08
`define PCC_OFS_MULTIPLIER_LOW 8'h0c
`define PCC_OFS_VCO_RANGE_SELECT 8'h10

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define PCC_LC_IRQ_EN 7
`define PCC_LC_FLAG 6
`define PCC_LC_PWR 5
`define PCC_LC_BCS 4
`define PCC_BW_AUTO 7
`define PCC_BW_LOCK 6
`define PCC_BW_ACQ 5

// ------------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------------
`define PCC_RST_MUL_HIGH 4'h0
`define PCC_RST_MUL_LOW 8'h40
`define PCC_RST_RANGE 8'h40
`define PCC_SWITCH_EDGES 2'h3
`define PCC_RESP_OKAY 2'h0
`define PCC_RESP_SLVERR 2'h2

`endif

// ---- include/pcc_pkg.sv ----
// Types shared by the loop clock control block.
package pcc_pkg;

	// Base clock switchover states.
	typedef enum logic [1:0] {
		PCC_ST_RUN = 2'b00,
		PCC_ST_OLD = 2'b01,
		PCC_ST_NEW = 2'b10
	} pcc_switch_t;

	// One register byte.
	typedef logic [7:0] pcc_byte_t;

endpackage

// ---- rtl/pcc_regs.sv ----
// Register and control logic of the loop clock generator, with an AXI4-Lite slave.
//
// Contract
// - Lock-change flag sets on every lock toggle
// - Interrupt when flag and enable both set
// - Flag reads zero in manual mode
// - Reading loop control clears flag; reset too
// - Power bit resets set; held while select
// - Select picks VCO or crystal, halved
// - Select cannot set while power off
// - Output static through three-plus-three edge switchover
// - Octave code gives multiplier one, two, four
// - Octave writes ignored while power on
// - Mode bit: automatic one, manual zero
// - Lock reads status in automatic, else zero
// - Acquisition bit: status automatic, control manual
// - Manual acquisition value kept through automatic
// - Twelve-bit multiplier resets to sixty-four
// - Multiplier zero behaves as one
// - Multiplier writes ignored while power on
// - High multiplier upper nibble reads zero
// - Range writes ignored while on; reset 0x40
// - Zero range disables loop, clears select
// - Interrupt enable forced zero in manual mode
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pcc_params.svh"

module pcc_regs
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_crystal_clock,
	input wire logic i_vco_clock,
	input wire logic i_lock_detect,
	input wire logic i_track_detect,
	output logic o_base_clock_out,
	output logic o_clock_generator_irq,
	output logic o_loop_enable,
	output logic o_acquisition_mode,
	output logic [11:0] o_feedback_multiplier,
	output logic [1:0] o_vco_octave,
	output logic [7:0] o_vco_linear_range
);

	// Register index from a byte offset; 3'h7 marks an unmapped address.
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		case (addr)
			`PCC_OFS_LOOP_CONTROL: reg_index = 3'h0;
			`PCC_OFS_BANDWIDTH_CONTROL: reg_index = 3'h1;
			`PCC_OFS_MULTIPLIER_HIGH: reg_index = 3'h2;
			`PCC_OFS_MULTIPLIER_LOW: reg_index = 3'h3;
			`PCC_OFS_VCO_RANGE_SELECT: reg_index = 3'h4;
			default: reg_index = 3'h7;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] filt;
	logic [3:0] filt_q;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane;
	logic irq_en;
	logic lock_flag;
	logic loop_power_on;
	logic base_clock_select;
	logic [1:0] vco_octave;
	logic auto_mode;
	logic acq_manual;
	logic lock_ind_q;
	logic [3:0] mul_high;
	logic [7:0] mul_low;
	logic [7:0] vco_range;
	pcc_pkg::pcc_switch_t sw_state;
	logic cur_src;
	logic [1:0] edge_cnt;
	logic base_out;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [1:0] rresp;
	pcc_pkg::pcc_byte_t rbyte;

	// ------------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------------
	wire [3:0] pins = {i_track_detect, i_lock_detect, i_vco_clock, i_crystal_clock};

	// Three stages; the filtered level moves only once stages two and three agree.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			sync3 <= 4'h0;
			filt <= 4'h0;
			filt_q <= 4'h0;
		end
		else
		begin
			sync1 <= pins;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
			filt_q <= filt;
		end
	end

	// Rising edges of the sampled crystal and VCO clocks.
	wire xtal_rise = filt[0] & ~filt_q[0];
	wire vco_rise = filt[1] & ~filt_q[1];

	// ------------------------------------------------------------------
	// AXI4-Lite decode
	// ------------------------------------------------------------------
	// Address and data are taken independently and held until both are in.
	wire aw_take = i_awvalid & ~aw_held;
	wire w_take = i_wvalid & ~w_held;
	wire wr_go = aw_held & w_held & ~bvalid;
	wire [2:0] wr_idx = reg_index(aw_addr);
	wire wr_en = wr_go & w_lane;
	wire wr_lc = wr_en & (wr_idx == 3'h0);
	wire wr_bw = wr_en & (wr_idx == 3'h1);
	wire wr_mh = wr_en & (wr_idx == 3'h2);
	wire wr_ml = wr_en & (wr_idx == 3'h3);
	wire wr_rs = wr_en & (wr_idx == 3'h4);
	wire rd_go = i_arvalid & ~rvalid;
	wire [2:0] rd_idx = reg_index(i_araddr);
	wire rd_lc = rd_go & (rd_idx == 3'h0);

	assign o_awready = ~aw_held;
	assign o_wready = ~w_held;
	assign o_arready = ~rvalid;

	// Write channel holding registers and response.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `PCC_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (w_take)
			begin
				w_held <= 1'b1;
				w_byte <= i_wdata[7:0];
				w_lane <= i_wstrb[0];
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (wr_idx == 3'h7) ? `PCC_RESP_SLVERR : `PCC_RESP_OKAY;
			end
			else if (bvalid & i_bready)
			begin
				bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Status and derived values
	// ------------------------------------------------------------------
	wire range_zero = (vco_range == 8'h00);
	wire lock_ind = auto_mode & filt[2];
	wire lock_toggle = lock_ind ^ lock_ind_q;
	wire acq_eff = auto_mode ? filt[3] : acq_manual;
	wire flag_read = lock_flag & auto_mode;
	wire [11:0] mul_raw = {mul_high, mul_low};

	// Multiplier and octave outputs; zero multiplier acts as one.
	assign o_feedback_multiplier = (mul_raw == 12'h000) ? 12'h001 : mul_raw;
	assign o_vco_octave = vco_octave;
	assign o_vco_linear_range = vco_range;
	assign o_loop_enable = loop_power_on & ~range_zero;
	assign o_acquisition_mode = acq_eff;
	assign o_clock_generator_irq = flag_read & irq_en;
	assign o_base_clock_out = base_out;

	// ------------------------------------------------------------------
	// Loop control register
	// ------------------------------------------------------------------
	wire next_bcs_set = w_byte[`PCC_LC_BCS] & loop_power_on & ~range_zero;
	wire next_pwr = w_byte[`PCC_LC_PWR] | base_clock_select;

	// Flag, enable, power, select and octave; a new toggle beats a clearing read.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			lock_flag <= 1'b0;
			lock_ind_q <= 1'b0;
			irq_en <= 1'b0;
			loop_power_on <= 1'b1;
			base_clock_select <= 1'b0;
			vco_octave <= 2'h0;
		end
		else
		begin
			lock_ind_q <= lock_ind;
			lock_flag <= lock_toggle | (lock_flag & ~rd_lc);
			if (!auto_mode)
				irq_en <= 1'b0;
			else if (wr_lc)
				irq_en <= w_byte[`PCC_LC_IRQ_EN];
			if (wr_lc)
				loop_power_on <= next_pwr;
			if (range_zero)
				base_clock_select <= 1'b0;
			else if (wr_lc)
				base_clock_select <= next_bcs_set;
			if (wr_lc & ~loop_power_on)
				vco_octave <= w_byte[1:0];
		end
	end

	// ------------------------------------------------------------------
	// Bandwidth control register
	// ------------------------------------------------------------------
	// Mode bit and the manual acquisition value; the lock bit is never stored.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			auto_mode <= 1'b0;
			acq_manual <= 1'b0;
		end
		else if (wr_bw)
		begin
			auto_mode <= w_byte[`PCC_BW_AUTO];
			if (!auto_mode)
				acq_manual <= w_byte[`PCC_BW_ACQ];
		end
	end

	// ------------------------------------------------------------------
	// Multiplier and range registers
	// ------------------------------------------------------------------
	// All three are locked against writes while the loop is powered.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			mul_high <= `PCC_RST_MUL_HIGH;
			mul_low <= `PCC_RST_MUL_LOW;
			vco_range <= `PCC_RST_RANGE;
		end
		else if (!loop_power_on)
		begin
			if (wr_mh)
				mul_high <= w_byte[3:0];
			if (wr_ml)
				mul_low <= w_byte;
			if (wr_rs)
				vco_range <= w_byte;
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	wire [7:0] rd_lc_val = {irq_en, flag_read, loop_power_on, base_clock_select, 2'h0,
		vco_octave};
	wire [7:0] rd_bw_val = {auto_mode, lock_ind, acq_eff, 5'h00};
	wire [7:0] rd_mux = (rd_idx == 3'h0) ? rd_lc_val :
		(rd_idx == 3'h1) ? rd_bw_val :
		(rd_idx == 3'h2) ? {4'h0, mul_high} :
		(rd_idx == 3'h3) ? mul_low :
		(rd_idx == 3'h4) ? vco_range : 8'h00;

	// Read data is registered on the same edge that takes the address.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rvalid <= 1'b0;
			rbyte <= 8'h00;
			rresp <= `PCC_RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid <= 1'b1;
			rbyte <= rd_mux;
			rresp <= (rd_idx == 3'h7) ? `PCC_RESP_SLVERR : `PCC_RESP_OKAY;
		end
		else if (rvalid & i_rready)
		begin
			rvalid <= 1'b0;
		end
	end

	assign o_bvalid = bvalid;
	assign o_bresp = bresp;
	assign o_rvalid = rvalid;
	assign o_rresp = rresp;
	assign o_rdata = {24'h000000, rbyte};

	// ------------------------------------------------------------------
	// Base clock selector
	// ------------------------------------------------------------------
	wire old_rise = cur_src ? vco_rise : xtal_rise;
	wire new_rise = cur_src ? xtal_rise : vco_rise;

	// Output halves the active source; during a switch it stands still.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			sw_state <= pcc_pkg::PCC_ST_RUN;
			cur_src <= 1'b0;
			edge_cnt <= 2'h0;
			base_out <= 1'b0;
		end
		else
		begin
			case (sw_state)
				pcc_pkg::PCC_ST_RUN:
				begin
					if (base_clock_select != cur_src)
					begin
						sw_state <= pcc_pkg::PCC_ST_OLD;
						edge_cnt <= 2'h0;
					end
					else if (old_rise)
						base_out <= ~base_out;
				end
				pcc_pkg::PCC_ST_OLD:
				begin
					if (old_rise)
						edge_cnt <= edge_cnt + 2'h1;
					if (old_rise && edge_cnt == `PCC_SWITCH_EDGES - 2'h1)
					begin
						sw_state <= pcc_pkg::PCC_ST_NEW;
						edge_cnt <= 2'h0;
					end
				end
				pcc_pkg::PCC_ST_NEW:
				begin
					if (new_rise)
						edge_cnt <= edge_cnt + 2'h1;
					if (new_rise && edge_cnt == `PCC_SWITCH_EDGES - 2'h1)
					begin
						sw_state <= pcc_pkg::PCC_ST_RUN;
						cur_src <= ~cur_src;
						edge_cnt <= 2'h0;
					end
				end
				default:
				begin
					sw_state <= pcc_pkg::PCC_ST_RUN;
				end
			endcase
		end
	end

endmodule // pcc_regs

// ---- sim/pcc_regs_props.sv ----
// Concurrent checks on the ports of the loop clock control registers.
`timescale 1ns/1ps

module pcc_regs_props
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_bready,
	input wire logic i_rready,
	input wire logic o_bvalid,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_loop_enable,
	input wire logic [11:0] o_feedback_multiplier,
	input wire logic [1:0] o_vco_octave,
	input wire logic [7:0] o_vco_linear_range
);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	reset_values_a: assert property ($fell(i_rst) |-> o_loop_enable &&
		o_vco_octave == 2'h0 && o_feedback_multiplier == 12'h040 &&
		o_vco_linear_range == 8'h40) else $error("bad values after reset");
	mult_nonzero_a: assert property (o_feedback_multiplier != 12'h000)
		else $error("multiplier shows zero");
	mult_locked_a: assert property (o_loop_enable |=> $stable(o_feedback_multiplier))
		else $error("multiplier changed while loop on");
	octave_locked_a: assert property (o_loop_enable |=> $stable(o_vco_octave))
		else $error("octave changed while loop on");
	range_locked_a: assert property (o_loop_enable |=> $stable(o_vco_linear_range))
		else $error("range changed while loop on");
	rdata_upper_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	read_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read answer not released");
	write_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write answer not released");
endmodule // pcc_regs_props

bind pcc_regs pcc_regs_props u_pcc_regs_props (.*);

// ---- sim/tb_top.sv ----
// Self-checking bench for the loop clock control registers.
`timescale 1ns/1ps
`include "pcc_params.svh"

module tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [7:0] lc = `PCC_OFS_LOOP_CONTROL;
	localparam logic [7:0] bw = `PCC_OFS_BANDWIDTH_CONTROL;
	localparam logic [7:0] mh = `PCC_OFS_MULTIPLIER_HIGH;
	localparam logic [7:0] ml = `PCC_OFS_MULTIPLIER_LOW;
	localparam logic [7:0] rs = `PCC_OFS_VCO_RANGE_SELECT;
	logic i_sys_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic i_crystal_clock, i_vco_clock, i_lock_detect, i_track_detect, p;
	logic [7:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata, d;
	logic [3:0] i_wstrb;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_base_clock_out;
	logic o_clock_generator_irq, o_loop_enable, o_acquisition_mode;
	logic [1:0] o_bresp, o_rresp, o_vco_octave;
	logic [11:0] o_feedback_multiplier;
	logic [7:0] o_vco_linear_range;
	logic [33:0] notes[$];
	logic [1:0] bnotes[$];
	int mismatches, samples_checked, seed, k, n;

	pcc_regs u_pcc_regs (.*);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
		@(posedge i_sys_clk);
		bnotes.push_back(r);
		i_awaddr <= a;
		i_wdata <= {24'h0, v};
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do
		begin
			@(posedge i_sys_clk);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
		end
		while (!o_bvalid);
		i_bready <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		notes.push_back({r, 24'h0, e});
		do @(posedge i_sys_clk); while (!o_arready);
		i_arvalid <= 1'h0;
		do @(posedge i_sys_clk); while (!o_rvalid);
		i_rready <= 1'h0;
	endtask

	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Processes
	// ------------------------------------------------------------
	// Clock, the slow source clocks and the read and write answer watcher.
	initial
	begin
		i_sys_clk = 1'h0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk)
	begin
		k <= k + 1;
		if (k % 4 == 3) i_crystal_clock <= ~i_crystal_clock;
		if (k % 3 == 2) i_vco_clock <= ~i_vco_clock;
		if (o_rvalid && i_rready) chk("read", {o_rresp, o_rdata}, notes.pop_front());
		if (o_bvalid && i_bready) chk("wresp", o_bresp, bnotes.pop_front());
	end

	// Watchdog against a hung handshake.
	initial
	begin
		repeat (20000) @(posedge i_sys_clk);
		mismatches++;
		close_out();
	end

	// Main sequence.
	initial
	begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, k} = '0;
		{i_crystal_clock, i_vco_clock, i_lock_detect, i_track_detect} = '0;
		{i_awaddr, i_araddr, i_wdata} = '0;
		i_wstrb = 4'hf;
		seed = 74;
		i_rst = 1'h1;
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		rd(lc, 8'h20);
		rd(bw, 8'h00);
		rd(mh, 8'h00);
		rd(ml, 8'h40);
		rd(rs, 8'h40);
		rd(8'h14, 8'h00, 2'h2);
		wr(8'h14, 8'h00, 2'h2);
		wr(ml, 8'h55);
		wr(rs, 8'h00);
		wr(lc, 8'h21);
		rd(ml, 8'h40);
		rd(rs, 8'h40);
		rd(lc, 8'h20);
		wr(lc, 8'h30);
		wr(lc, 8'h10);
		rd(lc, 8'h30);
		repeat (80) @(posedge i_sys_clk);
		n = 0;
		p = o_base_clock_out;
		repeat (240)
		begin
			@(posedge i_sys_clk);
			if (o_base_clock_out !== p) n++;
			p = o_base_clock_out;
		end
		chk("toggles", n inside {[39:41]}, 1);
		wr(lc, 8'h00);
		rd(lc, 8'h20);
		wr(lc, 8'h00);
		wr(lc, 8'h10);
		rd(lc, 8'h00);
		for (n = 0; n < 3; n++)
		begin
			wr(lc, n[7:0]);
			chk("octave", o_vco_octave, n[1:0]);
		end
		wr(lc, 8'h00);
		wr(mh, 8'hff);
		rd(mh, 8'h0f);
		wr(mh, 8'h00);
		wr(ml, 8'h00);
		chk("mult", o_feedback_multiplier, 12'h001);
		d = $random(seed);
		wr(ml, d[7:0]);
		rd(ml, d[7:0]);
		wr(rs, 8'h00);
		wr(lc, 8'h20);
		wr(lc, 8'h30);
		rd(lc, 8'h20);
		chk("enable", o_loop_enable, 0);
		wr(lc, 8'h00);
		wr(rs, 8'h40);
		wr(bw, 8'h20);
		chk("acq", o_acquisition_mode, 1);
		wr(lc, 8'h80);
		i_lock_detect <= 1'h1;
		repeat (8) @(posedge i_sys_clk);
		i_lock_detect <= 1'h0;
		repeat (8) @(posedge i_sys_clk);
		rd(lc, 8'h00);
		wr(bw, 8'ha0);
		chk("acq", o_acquisition_mode, 0);
		rd(bw, 8'h80);
		wr(lc, 8'h80);
		i_lock_detect <= 1'h1;
		repeat (8) @(posedge i_sys_clk);
		chk("irq", o_clock_generator_irq, 1);
		rd(bw, 8'hc0);
		rd(lc, 8'hc0);
		repeat (2) @(posedge i_sys_clk);
		chk("irq", o_clock_generator_irq, 0);
		rd(lc, 8'h80);
		i_lock_detect <= 1'h0;
		i_track_detect <= 1'h1;
		repeat (8) @(posedge i_sys_clk);
		chk("acq", o_acquisition_mode, 1);
		rd(bw, 8'ha0);
		rd(lc, 8'hc0);
		wr(bw, 8'h00);
		rd(bw, 8'h20);
		rd(lc, 8'h00);
		close_out();
	end
endmodule // tb_top
